//--- common/ihbcd_pkg.sv
`default_nettype none
package ihbcd_pkg;
    // ==================================================
    // register map (word index on the plain port)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RELOAD = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_LINES = 4'h4;
    // ==================================================
    // sequence control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_RSTART = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_W = 3;
    // ==================================================
    // status / mask bits
    localparam int ST_COLL = 0;
    localparam int ST_EVENT = 1;
    localparam int ST_W = 2;
    // ==================================================
    // reset values and the minimum reload
    localparam logic [7:0] RELOAD_RST = 8'h4f;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [ST_W-1:0] ST_RST = 2'h0;
    localparam logic [ST_W-1:0] MASK_RST = 2'h0;
    localparam logic [7:0] RELOAD_MIN = 8'h03;
    // ==================================================
    typedef enum {
        IHB_IDLE,
        IHB_S_WAIT,
        IHB_S_CNT1,
        IHB_S_CNT2,
        IHB_R_CNT0,
        IHB_R_SCLH,
        IHB_R_CNT1,
        IHB_R_CNT2,
        IHB_P_SDAL,
        IHB_P_SCLH,
        IHB_P_CNT,
        IHB_P_CHK
    } ihb_state_type;
endpackage : ihbcd_pkg
`default_nettype wire

//--- common/ihb_brg_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// link between sequencer and baud rate generator
interface ihb_brg_if;
    logic load;
    logic stop;
    logic [7:0] reload;
    logic expired;
    logic running;
    modport ctl (output load, output stop, output reload, input expired, input running);
    modport gen (input load, input stop, input reload, output expired, output running);
endinterface : ihb_brg_if
`default_nettype wire

//--- logic/ihb_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// baud rate generator: load, count down, one-cycle expiry
module ihb_baud_gen (
    input wire logic clk,
    input wire logic rst_n,
    ihb_brg_if.gen brg
);
    import ihbcd_pkg::*;
    logic [7:0] cnt_r;
    logic run_r;
    logic exp_r;
    wire cnt_zero = (cnt_r == 8'h00);
    // count and expiry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else if (brg.stop) begin
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else if (brg.load) begin
            cnt_r <= brg.reload;
            run_r <= 1'b1;
            exp_r <= 1'b0;
        end else if (run_r) begin
            cnt_r <= cnt_zero ? cnt_r : cnt_r - 8'h01;
            run_r <= !cnt_zero;
            exp_r <= cnt_zero;
        end else begin
            exp_r <= 1'b0;
        end
    end
    assign brg.expired = exp_r;
    assign brg.running = run_r;
endmodule : ihb_baud_gen
`default_nettype wire

//--- logic/ihb_stop_watch.sv
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// bus stop detector: sda rising while scl high
module ihb_stop_watch (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic stop_seen
);
    import ihbcd_pkg::*;
    logic sda_d_r;
    // previous sda level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_d_r <= 1'b1;
        end else begin
            sda_d_r <= sda_in;
        end
    end
    assign stop_seen = scl_in && sda_in && !sda_d_r;
endmodule : ihb_stop_watch
`default_nettype wire

//--- logic/ihb_collision_detect.sv
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: start sees either line low: collision
// R2: scl low before sda pulled: collision
// R3: start collision aborts, flags, returns idle
// R4: start with both lines high: loads generator
// R5: scl low with sda high: collision
// R6: sda low early: reset generator, drive
// R7: count expires: drive sda, reload, count
// R8: second start count ignores scl; then scl low
// R9: sda low when scl rises: collision
// R10: repeated start: count, release scl, sample
// R11: sda high: reload; sda falling fine
// R12: scl falls before sda driven: collision
// R13: both high: drive sda, count, scl low
// R14: stop: sda low, release scl, count
// R15: after count, sda released, low: collision
// R16: scl low before sda floats: collision
// R17: collision releases lines, clears enables
// R18: after collision, stop seen sets event
// R19: collision flag sticky until software clears
module ihb_collision_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_n,
    output logic sda_out,
    output logic sda_oe_n,
    output logic irq
);
    import ihbcd_pkg::*;

    // ==================================================
    // registers and state
    ihb_state_type state_r, state_nxt;
    logic [CTRL_W-1:0] ctrl_r;
    logic [7:0] reload_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic [7:0] rdata_r;
    logic scl_drv_r, scl_drv_nxt;
    logic sda_drv_r, sda_drv_nxt;
    logic scl_oe_n_r, sda_oe_n_r;
    logic irq_r;
    logic scl_d_r;
    logic watch_r;
    logic coll_ev, done_ev, load_c, stop_c;
    logic stop_seen;

    ihb_brg_if brg ();

    ihb_baud_gen u_brg (
        .clk(clk),
        .rst_n(rst_n),
        .brg(brg)
    );

    ihb_stop_watch u_stop (
        .clk(clk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .stop_seen(stop_seen)
    );

    // ==================================================
    // decode
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_reload = reg_wr && (reg_addr == ADDR_RELOAD);
    wire wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    wire wr_mask = reg_wr && (reg_addr == ADDR_MASK);
    wire idle = (state_r == IHB_IDLE);
    wire scl_rise = scl_in && !scl_d_r;
    wire scl_fall = !scl_in && scl_d_r;
    wire [7:0] reload_eff = (reload_r < RELOAD_MIN) ? RELOAD_MIN : reload_r;
    wire ev_stop = watch_r && stop_seen; // see R18

    function automatic logic [7:0] rd_mux(input logic [3:0] a, input logic [CTRL_W-1:0] c,
                                          input logic [7:0] rl, input logic [ST_W-1:0] s,
                                          input logic [ST_W-1:0] m, input logic sc, input logic sd);
        case (a)
            ADDR_CTRL: rd_mux = {5'h00, c};
            ADDR_RELOAD: rd_mux = rl;
            ADDR_STATUS: rd_mux = {6'h00, s};
            ADDR_MASK: rd_mux = {6'h00, m};
            ADDR_LINES: rd_mux = {6'h00, sd, sc};
            default: rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    // ==================================================
    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        scl_drv_nxt = scl_drv_r;
        sda_drv_nxt = sda_drv_r;
        coll_ev = 1'b0;
        done_ev = 1'b0;
        load_c = 1'b0;
        stop_c = 1'b0;
        case (state_r)
            IHB_IDLE: begin
                if (ctrl_r[CTRL_START]) begin
                    if (!sda_in || !scl_in) begin
                        coll_ev = 1'b1; // see R1
                    end else begin
                        load_c = 1'b1; // see R4
                        state_nxt = IHB_S_CNT1;
                    end
                end else if (ctrl_r[CTRL_RSTART]) begin
                    sda_drv_nxt = 1'b0;
                    state_nxt = IHB_S_WAIT;
                end else if (ctrl_r[CTRL_STOP]) begin
                    sda_drv_nxt = 1'b1; // see R14
                    state_nxt = IHB_P_SDAL;
                end
            end
            IHB_S_WAIT: begin
                if (sda_in) begin
                    load_c = 1'b1; // see R10
                    state_nxt = IHB_R_CNT0;
                end
            end
            IHB_S_CNT1: begin
                if (!sda_in) begin
                    load_c = 1'b1; // see R6
                    sda_drv_nxt = 1'b1;
                    state_nxt = IHB_S_CNT2;
                end else if (!scl_in) begin
                    coll_ev = 1'b1; // see R2 R5
                end else if (brg.expired) begin
                    load_c = 1'b1; // see R7
                    sda_drv_nxt = 1'b1;
                    state_nxt = IHB_S_CNT2;
                end
            end
            IHB_S_CNT2: begin
                if (brg.expired) begin
                    scl_drv_nxt = 1'b1; // see R8
                    done_ev = 1'b1;
                end
            end
            IHB_R_CNT0: begin
                if (brg.expired) begin
                    scl_drv_nxt = 1'b0; // see R10
                    state_nxt = IHB_R_SCLH;
                end
            end
            IHB_R_SCLH: begin
                if (scl_rise || scl_in) begin
                    if (!sda_in) begin
                        coll_ev = 1'b1; // see R9
                    end else begin
                        load_c = 1'b1; // see R11
                        state_nxt = IHB_R_CNT1;
                    end
                end
            end
            IHB_R_CNT1: begin
                if (scl_fall && sda_in) begin
                    coll_ev = 1'b1; // see R12
                end else if (brg.expired) begin
                    if (scl_in && sda_in) begin
                        sda_drv_nxt = 1'b1; // see R13
                        load_c = 1'b1;
                        state_nxt = IHB_R_CNT2;
                    end else if (!sda_in) begin
                        sda_drv_nxt = 1'b1; // see R11
                        load_c = 1'b1;
                        state_nxt = IHB_R_CNT2;
                    end else begin
                        coll_ev = 1'b1; // see R12
                    end
                end
            end
            IHB_R_CNT2: begin
                if (brg.expired) begin
                    scl_drv_nxt = 1'b1; // see R13
                    done_ev = 1'b1;
                end
            end
            IHB_P_SDAL: begin
                if (!sda_in) begin
                    scl_drv_nxt = 1'b0; // see R14
                    state_nxt = IHB_P_SCLH;
                end
            end
            IHB_P_SCLH: begin
                if (scl_in) begin
                    load_c = 1'b1; // see R14
                    state_nxt = IHB_P_CNT;
                end
            end
            IHB_P_CNT: begin
                if (!scl_in) begin
                    coll_ev = 1'b1; // see R16
                end else if (brg.expired) begin
                    sda_drv_nxt = 1'b0;
                    load_c = 1'b1;
                    state_nxt = IHB_P_CHK;
                end
            end
            IHB_P_CHK: begin
                if (!scl_in) begin
                    coll_ev = 1'b1; // see R16
                end else if (brg.expired) begin
                    if (!sda_in) begin
                        coll_ev = 1'b1; // see R15
                    end else begin
                        done_ev = 1'b1;
                    end
                end
            end
            default: state_nxt = IHB_IDLE;
        endcase
        if (coll_ev || done_ev) begin
            state_nxt = IHB_IDLE; // see R3
            stop_c = 1'b1;
            if (coll_ev) begin
                scl_drv_nxt = 1'b0; // see R17
                sda_drv_nxt = 1'b0;
            end
        end
    end

    assign brg.load = load_c;
    assign brg.stop = stop_c;
    assign brg.reload = reload_eff;

    // ==================================================
    // sequencer state and line drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= IHB_IDLE;
            scl_drv_r <= 1'b0;
            sda_drv_r <= 1'b0;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            scl_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            scl_drv_r <= scl_drv_nxt;
            sda_drv_r <= sda_drv_nxt;
            scl_oe_n_r <= !scl_drv_nxt; // pin enables leave straight from a flop
            sda_oe_n_r <= !sda_drv_nxt;
            scl_d_r <= scl_in;
        end
    end

    // ==================================================
    // sequence control: software sets, hardware clears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
        end else if (coll_ev || done_ev) begin
            ctrl_r <= CTRL_RST; // see R17
        end else if (wr_ctrl && idle) begin
            ctrl_r <= reg_wdata[CTRL_W-1:0];
        end
    end

    // reload value and interrupt mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_r <= RELOAD_RST;
            mask_r <= MASK_RST;
        end else begin
            reload_r <= wr_reload ? reg_wdata : reload_r;
            mask_r <= wr_mask ? reg_wdata[ST_W-1:0] : mask_r;
        end
    end

    // sticky status: set wins over write-one-to-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= ST_RST;
        end else begin
            status_r[ST_COLL] <= coll_ev || (status_r[ST_COLL]
                                 && !(wr_status && reg_wdata[ST_COLL])); // see R19
            status_r[ST_EVENT] <= done_ev || ev_stop || (status_r[ST_EVENT]
                                  && !(wr_status && reg_wdata[ST_EVENT]));
        end
    end

    // post-collision stop watch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watch_r <= 1'b0;
        end else begin
            watch_r <= coll_ev || (watch_r && !stop_seen); // see R18
        end
    end

    // read port and interrupt output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            rdata_r <= reg_rd ? rd_mux(reg_addr, ctrl_r, reload_r, status_r, mask_r, scl_in, sda_in) : 8'h00;
            irq_r <= |(status_r & mask_r);
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = scl_oe_n_r;
    assign sda_oe_n = sda_oe_n_r;

    // ==================================================
    // assertions
    a_start_low_coll: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        (idle && ctrl_r[CTRL_START] && !sda_in) |=> status_r[ST_COLL] && idle)
        else $error("start on low sda not flagged");
    a_coll_release: assert property (@(posedge clk) disable iff (!rst_n) // see R17
        coll_ev |=> scl_oe_n && sda_oe_n && ctrl_r == CTRL_RST)
        else $error("collision did not release lines");
    a_coll_sticky: assert property (@(posedge clk) disable iff (!rst_n) // see R19
        (status_r[ST_COLL] && !wr_status) |=> status_r[ST_COLL])
        else $error("collision flag dropped");
    a_early_sda: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        (state_r == IHB_S_CNT1 && !sda_in) |=> !sda_oe_n && !status_r[ST_COLL] || $past(status_r[ST_COLL]))
        else $error("early sda not driven");
    a_stop_release: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        (state_r == IHB_P_SDAL && !sda_in) |=> scl_oe_n)
        else $error("scl not released in stop");
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        |(status_r & mask_r) |=> irq)
        else $error("irq not raised");
    a_rstart_coll: assert property (@(posedge clk) disable iff (!rst_n) // see R9
        (state_r == IHB_R_SCLH && scl_in && !sda_in) |=> status_r[ST_COLL])
        else $error("repeated start collision missed");
    a_stop_event: assert property (@(posedge clk) disable iff (!rst_n) // see R18
        ev_stop |=> status_r[ST_EVENT])
        else $error("stop after collision not flagged");
    c_start_done: cover property (@(posedge clk) disable iff (!rst_n) state_r == IHB_S_CNT2 && done_ev);
    c_coll: cover property (@(posedge clk) disable iff (!rst_n) coll_ev);
    c_stop_done: cover property (@(posedge clk) disable iff (!rst_n) state_r == IHB_P_CHK && done_ev);
    c_rstart_done: cover property (@(posedge clk) disable iff (!rst_n) state_r == IHB_R_CNT2 && done_ev);
endmodule : ihb_collision_detect
`default_nettype wire

//--- verification/ihb_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// other hosts and clients on the shared open-drain bus
module ihb_bus_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic hold_scl,
    input wire logic hold_sda,
    input wire logic [3:0] stretch,
    output logic scl_in,
    output logic sda_in
);
    logic [3:0] wait_r;
    logic scl_oe_q_r;
    logic stretch_now;

    // a slow client keeps scl low a few cycles after the host lets go
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 4'h0;
            scl_oe_q_r <= 1'b1;
        end else begin
            scl_oe_q_r <= scl_oe_n;
            if (stretch_now) begin
                wait_r <= stretch;
            end else if (wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end

    // wired-and with pull-ups: a released line floats high
    assign stretch_now = scl_oe_n && !scl_oe_q_r && (stretch != 4'h0);
    assign scl_in = scl_oe_n & !hold_scl & !stretch_now & (wait_r == 4'h0);
    assign sda_in = sda_oe_n & !hold_sda;
endmodule : ihb_bus_partner
`default_nettype wire

//--- verification/ihb_collision_detect_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// collision detect bench
module ihb_collision_detect_tb;
    import ihbcd_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, scl_in, sda_in, scl_oe_n, sda_oe_n, irq, hold_scl, hold_sda;
    logic scl_out, sda_out;
    logic [3:0] reg_addr, stretch;
    logic [7:0] reg_wdata, reg_rdata, rv, rl;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 32'h5785;
    int k, c1, c2;
    logic [3:0] rst_adr [6] = '{ADDR_CTRL, ADDR_RELOAD, ADDR_STATUS, ADDR_MASK, ADDR_LINES, 4'hf};
    logic [7:0] rst_val [6] = '{8'h00, RELOAD_RST, 8'h00, 8'h00, 8'h03, 8'h00};

    ihb_collision_detect dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
    ihb_bus_partner partner (.clk(clk), .rst_n(rst_n), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
        .hold_scl(hold_scl), .hold_sda(hold_sda), .stretch(stretch), .scl_in(scl_in), .sda_in(sda_in));

    // ==================================================
    // expectations
    function automatic logic [7:0] st_exp(input logic coll, input logic ev);
        st_exp = 8'h00;
        st_exp[ST_COLL] = coll;
        st_exp[ST_EVENT] = ev;
    endfunction : st_exp
    function automatic logic [7:0] in_range(input int v, input int lo, input int hi);
        in_range = (v >= lo && v <= hi) ? 8'h01 : 8'h00;
    endfunction : in_range

    // ==================================================
    // bus tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    // poll control until the sequence has ended, bounded
    task automatic wait_idle;
        int i;
        i = 0;
        rd(ADDR_CTRL, rv);
        while (rv !== 8'h00 && i < 300) begin
            rd(ADDR_CTRL, rv);
            i++;
        end
        chk(in_range(i, 0, 299), 8'h01);
    endtask : wait_idle
    task automatic wait_oe(input logic on_scl, output int n);
        n = 0;
        while ((on_scl ? scl_oe_n : sda_oe_n) !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_oe
    // issue a sequence, let the far side pull lines after d cycles
    task automatic launch(input logic [7:0] c, input int d, input logic ps, input logic pd);
        wr(ADDR_CTRL, c);
        repeat (d) @(posedge clk);
        hold_scl <= ps;
        hold_sda <= pd;
        wait_idle();
    endtask : launch
    task automatic expect_st(input logic [7:0] e);
        rd(ADDR_STATUS, rv);
        chk(rv, e);
        wr(ADDR_STATUS, 8'h03);
    endtask : expect_st
    task automatic release_at(input int d);
        repeat (d) @(posedge clk);
        hold_scl <= 1'b0;
        hold_sda <= 1'b0;
    endtask : release_at
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // ==================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 50000);
        n_mismatch++;
        stop_test();
    end

    // ==================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        hold_scl = 1'b0;
        hold_sda = 1'b0;
        stretch = 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped word, read-only lines
        for (k = 0; k < 6; k++) begin
            rd(rst_adr[k], rv);
            chk(rv, rst_val[k]);
        end
        wr(ADDR_LINES, 8'h00);
        rd(ADDR_LINES, rv);
        chk(rv, 8'h03);
        rl = 8'h08 + 8'($random(seed) & 7);
        wr(ADDR_RELOAD, rl);
        wr(ADDR_MASK, 8'h03);
        // start against a line already low; irq masked and cleared
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            hold_scl <= (k == 0);
            hold_sda <= (k == 1);
            launch(8'h01, 0, k == 0, k == 1);
            chk({4'h0, scl_out, sda_out, scl_oe_n, sda_oe_n}, 8'h03);
            rd(ADDR_STATUS, rv);
            chk(rv, st_exp(1, 0));
            chk({7'h0, irq}, 8'h01);
            wr(ADDR_MASK, 8'h00);
            rd(ADDR_STATUS, rv);
            chk({7'h0, irq}, 8'h00);
            chk(rv, st_exp(1, 0));
            wr(ADDR_MASK, 8'h03);
            release_at(1);
            repeat (3) @(posedge clk);
            expect_st(st_exp(1, k == 1));
            rd(ADDR_STATUS, rv);
            chk({7'h0, irq}, 8'h00);
        end
        // sda pulled low in the first count: early drive, no collision
        wr(ADDR_CTRL, 8'h01);
        repeat (2) @(posedge clk);
        hold_sda <= 1'b1;
        wait_oe(1'b0, c1);
        chk(in_range(c1, 0, 3), 8'h01);
        release_at(1);
        wait_idle();
        expect_st(st_exp(0, 1));
        launch(8'h04, 0, 0, 0);
        expect_st(st_exp(0, 1));
        chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
        // scl pulled low while sda high in the first count
        launch(8'h01, 2 + ($random(seed) & 1), 1, 0);
        expect_st(st_exp(1, 0));
        release_at(1);
        // full start, timed, scl pulled in the second count
        rd(ADDR_LINES, rv);
        chk(rv, 8'h03);
        wr(ADDR_CTRL, 8'h01);
        wait_oe(1'b0, c1);
        chk(in_range(c1, rl + 1, rl + 5), 8'h01);
        @(posedge clk);
        hold_scl <= 1'b1;
        wait_oe(1'b1, c2);
        chk(in_range(c2, rl - 1, rl + 4), 8'h01);
        release_at(1);
        wait_idle();
        expect_st(st_exp(0, 1));
        // stop with sda held low by another party
        @(posedge clk);
        hold_sda <= 1'b1;
        launch(8'h04, 0, 0, 1);
        expect_st(st_exp(1, 0));
        chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
        release_at(1);
        repeat (3) @(posedge clk);
        expect_st(st_exp(0, 1));
        // stop broken by scl pulled during its count
        launch(8'h01, 0, 0, 0);
        expect_st(st_exp(0, 1));
        launch(8'h04, 7 + ($random(seed) & 1), 1, 0);
        expect_st(st_exp(1, 0));
        release_at(1);
        // repeated start with sda low when scl rises
        launch(8'h01, 0, 0, 0);
        expect_st(st_exp(0, 1));
        launch(8'h02, 4, 0, 1);
        expect_st(st_exp(1, 0));
        release_at(1);
        repeat (3) @(posedge clk);
        wr(ADDR_STATUS, 8'h03);
        // repeated start broken by scl pulled in the count after scl rises
        launch(8'h01, 0, 0, 0);
        expect_st(st_exp(0, 1));
        launch(8'h02, rl + 7, 1, 0);
        expect_st(st_exp(1, 0));
        release_at(1);
        // repeated start completed against a slow clock release
        launch(8'h01, 0, 0, 0);
        expect_st(st_exp(0, 1));
        @(posedge clk);
        stretch <= 4'h1 + 4'($random(seed) & 3);
        launch(8'h02, 0, 0, 0);
        expect_st(st_exp(0, 1));
        chk({7'h0, scl_oe_n}, 8'h00);
        @(posedge clk);
        stretch <= 4'h0;
        launch(8'h04, 0, 0, 0);
        expect_st(st_exp(0, 1));
        stop_test();
    end
endmodule : ihb_collision_detect_tb
`default_nettype wire
